/* srw_pkg.sv */
// Shared constants and types for the supervisory reset and watchdog block.
package srw_pkg;

  // Core clock rate used to turn times into cycle counts.
  localparam logic [63:0] CLK_HZ = 64'd125_000_000;
  localparam logic [63:0] US_PER_S = 64'd1_000_000;
  localparam logic [63:0] MS_PER_S = 64'd1_000;

  // Least watchdog timeouts in microseconds; index 0 and 1 normal, 2 and 3 extended.
  localparam logic [63:0] WD_T0_US = 64'd4_300;
  localparam logic [63:0] WD_T1_US = 64'd71_000;
  localparam logic [63:0] WD_T2_US = 64'd1_120_000;
  localparam logic [63:0] WD_T3_US = 64'd17_900_000;

  // Least timeouts round up to whole cycles.
  localparam logic [63:0] WD_CYC_0 = (WD_T0_US * CLK_HZ + US_PER_S - 64'd1) / US_PER_S;
  localparam logic [63:0] WD_CYC_1 = (WD_T1_US * CLK_HZ + US_PER_S - 64'd1) / US_PER_S;
  localparam logic [63:0] WD_CYC_2 = (WD_T2_US * CLK_HZ + US_PER_S - 64'd1) / US_PER_S;
  localparam logic [63:0] WD_CYC_3 = (WD_T3_US * CLK_HZ + US_PER_S - 64'd1) / US_PER_S;

  // Least reset hold times in milliseconds and their cycle counts.
  localparam logic [63:0] HOLD_T0_MS = 64'd1;
  localparam logic [63:0] HOLD_T1_MS = 64'd20;
  localparam logic [63:0] HOLD_T2_MS = 64'd140;
  localparam logic [63:0] HOLD_T3_MS = 64'd1120;
  localparam logic [63:0] HOLD_CYC_0 = (HOLD_T0_MS * CLK_HZ + MS_PER_S - 64'd1) / MS_PER_S;
  localparam logic [63:0] HOLD_CYC_1 = (HOLD_T1_MS * CLK_HZ + MS_PER_S - 64'd1) / MS_PER_S;
  localparam logic [63:0] HOLD_CYC_2 = (HOLD_T2_MS * CLK_HZ + MS_PER_S - 64'd1) / MS_PER_S;
  localparam logic [63:0] HOLD_CYC_3 = (HOLD_T3_MS * CLK_HZ + MS_PER_S - 64'd1) / MS_PER_S;

  // Active pull-up pulse on the shared reset line after release.
  localparam logic [63:0] PULLUP_T_NS = 64'd1_000;
  localparam logic [7:0] PULLUP_CYC = 8'((PULLUP_T_NS * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000);

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] WDCNT_OFS = 8'h08;
  localparam logic [7:0] HOLDCNT_OFS = 8'h0c;

  // Control field positions and reset value.
  localparam int CTRL_WD_EN = 0;
  localparam int CTRL_WD_EXT = 1;
  localparam int CTRL_WD_LONG = 2;
  localparam int CTRL_HOLD_LSB = 3;
  localparam int CTRL_UVA_EN = 5;
  localparam int CTRL_UVB_EN = 6;
  localparam int CTRL_OV_EN = 7;
  localparam int CTRL_MR_EN = 8;
  localparam logic [8:0] CTRL_RESET = 9'h138;

  // Status field positions.
  localparam int STAT_ACTIVE = 0;
  localparam int STAT_WD_SEEN = 5;
  localparam int STAT_LINE = 6;
  localparam int STAT_STATE_LSB = 7;

  // Reset sequencer states.
  typedef enum logic [1:0] {
    SRW_IDLE = 2'b00,
    SRW_ASSERT = 2'b01,
    SRW_HOLD = 2'b10
  } srw_state_type;

endpackage

/* srw_edge.sv */
// Edge detector that flags any transition of a synchronous input.
`timescale 1ns/1ps
module srw_edge (
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Sampled level and transition pulse.
  input wire logic level_in,
  output logic toggled
);

  logic prev_reg;

  // Previous level; a high input at release reads as one harmless extra kick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else if (ce) begin
      prev_reg <= level_in;
    end
  end

  // Rising and falling edges count alike.
  assign toggled = level_in ^ prev_reg;

endmodule

/* srw_timer.sv */
// Saturating up-counter that flags the last cycle of a programmable span.
`timescale 1ns/1ps
module srw_timer #(
  parameter int W = 32
) (
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Control and span.
  input wire logic clear,
  input wire logic [W-1:0] limit,
  // Progress.
  output logic [W-1:0] count,
  output logic done
);

  logic [W-1:0] count_reg;

  // Count stops on the last cycle so done stays up until cleared.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else if (ce) begin
      if (clear) begin
        count_reg <= '0;
      end else if (!done) begin
        count_reg <= count_reg + W'(1);
      end
    end
  end

  assign count = count_reg;
  // A span shortened below the present count still ends at once instead of wrapping.
  assign done = (count_reg >= limit - W'(1));

endmodule

/* srw_supervisor.sv */
// Supervisory reset generator with watchdog, voltage flags, manual reset and APB control.
//
// Function
// - Host toggles kick input within watchdog timeout, otherwise the device asserts reset.
// - Normal watchdog mode uses the 4.3 ms or 71 ms timeout.
// - Extended watchdog mode uses the 1.12 s or 17.9 s timeout.
// - Watchdog can be disabled; then missing kicks never cause reset.
// - Either undervoltage flag asserts reset.
// - The overvoltage flag asserts reset.
// - Manual reset low asserts reset, held until hold time after release.
// - Active-high output rises on any condition, falls after hold time.
// - Active-low output falls on any condition, rises after hold time.
// - Open-drain outputs drive only their asserted level, otherwise float.
// - Shared line pulls low during reset, then actively drives high briefly.
// - Hold time selects 1, 20, 140 or 1120 ms; 1120 ms default.
`timescale 1ns/1ps
module srw_supervisor #(
  parameter logic [31:0] WD_CYC_0 = 32'(srw_pkg::WD_CYC_0),
  parameter logic [31:0] WD_CYC_1 = 32'(srw_pkg::WD_CYC_1),
  parameter logic [31:0] WD_CYC_2 = 32'(srw_pkg::WD_CYC_2),
  parameter logic [31:0] WD_CYC_3 = 32'(srw_pkg::WD_CYC_3),
  parameter logic [31:0] HOLD_CYC_0 = 32'(srw_pkg::HOLD_CYC_0),
  parameter logic [31:0] HOLD_CYC_1 = 32'(srw_pkg::HOLD_CYC_1),
  parameter logic [31:0] HOLD_CYC_2 = 32'(srw_pkg::HOLD_CYC_2),
  parameter logic [31:0] HOLD_CYC_3 = 32'(srw_pkg::HOLD_CYC_3)
) (
  // Clock, reset and clock enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset sources.
  input wire logic watchdog_kick_in,
  input wire logic undervolt_flag_a,
  input wire logic undervolt_flag_b,
  input wire logic overvolt_flag,
  input wire logic manual_reset_n,
  // Push-pull reset outputs.
  output logic reset_out,
  output logic reset_n_out,
  // Open-drain reset outputs.
  output logic reset_open_drain_out_o,
  output logic reset_open_drain_out_oe,
  output logic reset_open_drain_n_out_o,
  output logic reset_open_drain_n_out_oe,
  // Bidirectional active-low reset line.
  input wire logic reset_bidir_n_i,
  output logic reset_bidir_n_o,
  output logic reset_bidir_n_oe
);

  // Zero spans would make limit - 1 wrap to all ones, so the timers would not expire in time.
  if (WD_CYC_0 == 32'h0 || WD_CYC_1 == 32'h0 || WD_CYC_2 == 32'h0 || WD_CYC_3 == 32'h0 ||
      HOLD_CYC_0 == 32'h0 || HOLD_CYC_1 == 32'h0 || HOLD_CYC_2 == 32'h0 || HOLD_CYC_3 == 32'h0) begin : g_bad
    $error("srw_supervisor: every timeout count must be at least one cycle");
  end

  logic [8:0] ctrl_reg;
  logic wd_seen_reg;
  logic active_reg;
  logic [7:0] pullup_reg;
  logic [31:0] prdata_reg;
  logic valid_reg;
  srw_pkg::srw_state_type state_reg;
  srw_pkg::srw_state_type state_next;
  logic kick;
  logic wd_en;
  logic wd_trip;
  logic wd_clear;
  logic hold_done;
  logic cond;
  logic src_uva;
  logic src_uvb;
  logic src_ov;
  logic src_mr;
  logic [31:0] wd_limit;
  logic [31:0] hold_limit;
  logic [31:0] wd_count;
  logic [31:0] hold_count;
  logic [1:0] hold_sel;
  logic addr_ok;
  logic wr_en;

  // Kick transitions from the host.
  srw_edge u_kick (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .level_in(watchdog_kick_in),
    .toggled(kick)
  );

  // Watchdog span from the mode and length bits.
  always_comb begin
    case ({ctrl_reg[srw_pkg::CTRL_WD_EXT], ctrl_reg[srw_pkg::CTRL_WD_LONG]})
      2'b00: wd_limit = WD_CYC_0;
      2'b01: wd_limit = WD_CYC_1;
      2'b10: wd_limit = WD_CYC_2;
      default: wd_limit = WD_CYC_3;
    endcase
  end

  // Hold span selection.
  assign hold_sel = ctrl_reg[srw_pkg::CTRL_HOLD_LSB +: 2];
  always_comb begin
    case (hold_sel)
      2'b00: hold_limit = HOLD_CYC_0;
      2'b01: hold_limit = HOLD_CYC_1;
      2'b10: hold_limit = HOLD_CYC_2;
      default: hold_limit = HOLD_CYC_3;
    endcase
  end

  // Watchdog restarts on every kick, while disabled and throughout reset.
  assign wd_en = ctrl_reg[srw_pkg::CTRL_WD_EN];
  assign wd_clear = kick || !wd_en || active_reg;

  srw_timer #(
    .W(32)
  ) u_wd (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .clear(wd_clear),
    .limit(wd_limit),
    .count(wd_count),
    .done(wd_trip)
  );

  // Individually enabled reset sources; flags are high when out of range.
  assign src_uva = ctrl_reg[srw_pkg::CTRL_UVA_EN] && undervolt_flag_a;
  assign src_uvb = ctrl_reg[srw_pkg::CTRL_UVB_EN] && undervolt_flag_b;
  assign src_ov = ctrl_reg[srw_pkg::CTRL_OV_EN] && overvolt_flag;
  assign src_mr = ctrl_reg[srw_pkg::CTRL_MR_EN] && !manual_reset_n;
  assign cond = src_uva || src_uvb || src_ov || src_mr || (wd_en && wd_trip);

  // Hold timer only runs once every source has gone quiet.
  srw_timer #(
    .W(32)
  ) u_hold (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .clear(state_reg != srw_pkg::SRW_HOLD || cond),
    .limit(hold_limit),
    .count(hold_count),
    .done(hold_done)
  );

  // Sequencer: a live source always wins over an expiring hold.
  always_comb begin
    case (state_reg)
      srw_pkg::SRW_IDLE: state_next = cond ? srw_pkg::SRW_ASSERT : srw_pkg::SRW_IDLE;
      srw_pkg::SRW_ASSERT: state_next = cond ? srw_pkg::SRW_ASSERT : srw_pkg::SRW_HOLD;
      srw_pkg::SRW_HOLD: begin
        if (cond) begin
          state_next = srw_pkg::SRW_ASSERT;
        end else if (hold_done) begin
          state_next = srw_pkg::SRW_IDLE;
        end else begin
          state_next = srw_pkg::SRW_HOLD;
        end
      end
      default: state_next = srw_pkg::SRW_ASSERT;
    endcase
  end

  // Power-up starts in hold so the system sees a full reset pulse after release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= srw_pkg::SRW_HOLD;
      active_reg <= 1'b1;
    end else if (ce) begin
      state_reg <= state_next;
      active_reg <= (state_next != srw_pkg::SRW_IDLE);
    end
  end

  // Pull-up pulse after release, short so a processor can still pull the line itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_reg <= 8'h00;
    end else if (ce) begin
      if (active_reg && state_next == srw_pkg::SRW_IDLE) begin
        pullup_reg <= srw_pkg::PULLUP_CYC;
      end else if (active_reg) begin
        pullup_reg <= 8'h00;
      end else if (pullup_reg != 8'h00) begin
        pullup_reg <= pullup_reg - 8'h01;
      end
    end
  end

  // Reset pins follow one registered state; the shared line's drive enable also follows the pull-up pulse.
  assign reset_out = active_reg;
  assign reset_n_out = !active_reg;
  assign reset_open_drain_out_o = 1'b1;
  assign reset_open_drain_out_oe = active_reg;
  assign reset_open_drain_n_out_o = 1'b0;
  assign reset_open_drain_n_out_oe = active_reg;
  assign reset_bidir_n_o = !active_reg;
  assign reset_bidir_n_oe = active_reg || (pullup_reg != 8'h00);

  // Bus decode; pready waits for read data captured on an enabled edge.
  assign addr_ok = (paddr == srw_pkg::CTRL_OFS) || (paddr == srw_pkg::STATUS_OFS) ||
                   (paddr == srw_pkg::WDCNT_OFS) || (paddr == srw_pkg::HOLDCNT_OFS);
  assign pready = penable && valid_reg && ce;
  assign pslverr = pready && !addr_ok;
  assign wr_en = psel && pready && pwrite && addr_ok;
  assign prdata = prdata_reg;

  // Read data capture tracks the current transfer until it completes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      valid_reg <= 1'b0;
    end else if (ce) begin
      valid_reg <= psel && !pready;
      if (psel && !pready) begin
        case (paddr)
          srw_pkg::CTRL_OFS: prdata_reg <= {23'h000000, ctrl_reg};
          srw_pkg::STATUS_OFS: prdata_reg <= {23'h000000, state_reg, reset_bidir_n_i, wd_seen_reg,
                                              src_mr, src_ov, src_uvb, src_uva, active_reg};
          srw_pkg::WDCNT_OFS: prdata_reg <= wd_count;
          srw_pkg::HOLDCNT_OFS: prdata_reg <= hold_count;
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control register, byte lanes honoured.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= srw_pkg::CTRL_RESET;
    end else if (wr_en && paddr == srw_pkg::CTRL_OFS) begin
      if (pstrb[0]) begin
        ctrl_reg[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        ctrl_reg[8] <= pwdata[8];
      end
    end
  end

  // Sticky watchdog-expiry flag; a new expiry beats a write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_seen_reg <= 1'b0;
    end else if (ce) begin
      if (wd_en && wd_trip) begin
        wd_seen_reg <= 1'b1;
      end else if (wr_en && paddr == srw_pkg::STATUS_OFS && pstrb[0] && pwdata[srw_pkg::STAT_WD_SEEN]) begin
        wd_seen_reg <= 1'b0;
      end
    end
  end

  // Checks on the sequencer and its outputs.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_cond_gone;
    ce && state_reg == srw_pkg::SRW_ASSERT && !cond;
  endsequence

  sequence s_hold_end;
    ce && state_reg == srw_pkg::SRW_HOLD && !cond && hold_done;
  endsequence

  chk_wd_trip_reset: assert property ((ce && wd_en && wd_trip) |=> reset_out)
    else $error("watchdog expiry did not assert reset");

  chk_wd_normal_span: assert property (!ctrl_reg[srw_pkg::CTRL_WD_EXT] |->
    wd_limit == (ctrl_reg[srw_pkg::CTRL_WD_LONG] ? WD_CYC_1 : WD_CYC_0))
    else $error("normal watchdog span wrong");

  chk_wd_ext_span: assert property (ctrl_reg[srw_pkg::CTRL_WD_EXT] |->
    wd_limit == (ctrl_reg[srw_pkg::CTRL_WD_LONG] ? WD_CYC_3 : WD_CYC_2))
    else $error("extended watchdog span wrong");

  chk_wd_off_quiet: assert property ((ce && !wd_en) |=> (wd_count == 32'h0))
    else $error("disabled watchdog kept counting");

  chk_uv_asserts: assert property ((ce && (src_uva || src_uvb)) |=>
    (state_reg == srw_pkg::SRW_ASSERT && reset_out))
    else $error("undervoltage flag did not assert reset");

  chk_ov_asserts: assert property ((ce && src_ov) |=> (state_reg == srw_pkg::SRW_ASSERT && !reset_n_out))
    else $error("overvoltage flag did not assert reset");

  chk_mr_release_hold: assert property ((s_cond_gone and src_mr == 1'b0) |=>
    (reset_out && hold_count == 32'h0) ##1 reset_out)
    else $error("manual reset release did not hold reset");

  chk_out_polarity: assert property (reset_out == !reset_n_out && reset_out == active_reg)
    else $error("push-pull reset outputs disagree");

  chk_hold_release: assert property (s_hold_end |=> (!reset_out && reset_n_out))
    else $error("reset not released after hold span");

  chk_hold_early: assert property ((ce && state_reg == srw_pkg::SRW_HOLD && !hold_done) |=> reset_out)
    else $error("reset released before hold span ended");

  chk_od_levels: assert property (reset_open_drain_out_oe == reset_out && reset_open_drain_n_out_oe == reset_out
    && reset_open_drain_out_o && !reset_open_drain_n_out_o)
    else $error("open-drain outputs drove the wrong level");

  chk_bidir_pull: assert property (s_hold_end |=> (reset_bidir_n_oe && reset_bidir_n_o) ##1
    (reset_bidir_n_oe && (reset_bidir_n_o || reset_out)))
    else $error("shared reset line not driven high after release");

  chk_bidir_low: assert property (reset_out |-> (reset_bidir_n_oe && !reset_bidir_n_o))
    else $error("shared reset line not pulled low during reset");

  chk_hold_span: assert property (hold_limit == (hold_sel == 2'b00 ? HOLD_CYC_0 : hold_sel == 2'b01 ?
    HOLD_CYC_1 : hold_sel == 2'b10 ? HOLD_CYC_2 : HOLD_CYC_3))
    else $error("hold span selection wrong");

  chk_cond_restart: assert property ((ce && cond) |=> (hold_count == 32'h0 && reset_out))
    else $error("active source did not restart hold");

  chk_wd_kick_clear: assert property ((ce && (kick || active_reg)) |=> (wd_count == 32'h0))
    else $error("watchdog count not cleared by kick or reset");

  chk_mr_asserts: assert property ((ce && src_mr) |=> (reset_out && !reset_n_out))
    else $error("manual reset did not assert reset");

  chk_freeze_hold: assert property (!ce |=> ($stable(state_reg) && $stable(active_reg) && $stable(hold_count)))
    else $error("sequencer moved while the clock enable was low");

endmodule

/* srw_host_model.sv */
// Host-side model that kicks the watchdog and resolves the shared reset line.
`timescale 1ns/1ps
module srw_host_model #(
  parameter int KICK_PERIOD = 8
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Kick control and kick level.
  input wire logic kick_en,
  output logic kick,
  // Shared active-low reset line.
  input wire logic line_o,
  input wire logic line_oe,
  output wire logic line
);
  int cnt;

  // The resistor pull-up holds the line high whenever nobody drives it.
  assign line = line_oe ? line_o : 1'b1;

  // Toggle the kick level once per period, so rising and falling kicks alternate.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      kick <= 1'b0;
    end else if (kick_en && cnt == KICK_PERIOD - 1) begin
      cnt <= 0;
      kick <= ~kick;
    end else if (kick_en) begin
      cnt <= cnt + 1;
    end
  end
endmodule

/* tb_top.sv */
// Self-checking testbench for the supervisory reset and watchdog block.
`timescale 1ns/1ps
module tb_top;
  localparam logic [3:0][31:0] wdl = {32'd50, 32'd40, 32'd30, 32'd20};
  localparam logic [3:0][31:0] hdl = {32'd16, 32'd12, 32'd10, 32'd8};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic [3:0] pstrb = 4'hf;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, kick, kick_q;
  logic kick_en = 1'b0;
  logic manual_reset_n = 1'b1;
  logic [2:0] flags = 3'h0;
  logic reset_out, reset_n_out, od_o, od_oe, odn_o, odn_oe, bid_o, bid_oe;
  wire logic bid_line;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int since = 0;
  int n;

  // Short spans keep every scenario to a few hundred cycles.
  srw_supervisor #(.WD_CYC_0(wdl[0]), .WD_CYC_1(wdl[1]), .WD_CYC_2(wdl[2]), .WD_CYC_3(wdl[3]),
    .HOLD_CYC_0(hdl[0]), .HOLD_CYC_1(hdl[1]), .HOLD_CYC_2(hdl[2]), .HOLD_CYC_3(hdl[3])) srw_supervisor_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .watchdog_kick_in(kick), .undervolt_flag_a(flags[0]), .undervolt_flag_b(flags[1]),
    .overvolt_flag(flags[2]), .manual_reset_n(manual_reset_n), .reset_out(reset_out),
    .reset_n_out(reset_n_out), .reset_open_drain_out_o(od_o), .reset_open_drain_out_oe(od_oe),
    .reset_open_drain_n_out_o(odn_o), .reset_open_drain_n_out_oe(odn_oe), .reset_bidir_n_i(bid_line),
    .reset_bidir_n_o(bid_o), .reset_bidir_n_oe(bid_oe));

  srw_host_model srw_host_model_i (.pclk(pclk), .presetn(presetn), .kick_en(kick_en), .kick(kick),
    .line_o(bid_o), .line_oe(bid_oe), .line(bid_line));

  // Free-running clock at 125 MHz.
  initial begin
    forever #4 pclk = ~pclk;
  end

  // Cycle ceiling cuts a hang short; the cycles since the last kick give the expiry distance.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    kick_q <= kick;
    since <= (kick !== kick_q) ? 0 : since + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high, only the cycle ceiling ends a wait.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] ctrl(logic en, logic ext, logic lng, logic [1:0] hold, logic [3:0] src);
    return {23'h0, src, hold, lng, ext, en};
  endfunction

  // Counts edges until the active-high reset reaches the wanted level.
  task automatic wait_rst(input logic lvl);
    n = 0;
    while (reset_out !== lvl && n < 500) begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask

  task automatic check_out(input logic a);
    check("reset outputs", {reset_out, reset_n_out, od_o, od_oe, odn_o, odn_oe, bid_o, bid_line},
      {a, ~a, 1'b1, a, 1'b0, a, ~a, ~a});
  endtask

  // Raise sources w = {manual, over, under b, under a}, drop them, then time the hold span.
  task automatic trip(input logic [3:0] w, input int hexp);
    @(posedge pclk);
    flags <= w[2:0];
    manual_reset_n <= ~w[3];
    wait_rst(1'b1);
    check("assert delay", 32'(n >= 1 && n <= 2), 32'h1);
    check_out(1'b1);
    repeat (3) @(posedge pclk);
    flags <= 3'h0;
    manual_reset_n <= 1'b1;
    wait_rst(1'b0);
    check("hold span", n, hexp + 1);
    check("pull-up drive", {bid_oe, bid_o}, 2'b11);
    check_out(1'b0);
  endtask

  // Main sequence.
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, srw_pkg::CTRL_OFS, 32'h0);
    check("control reset value", rd, 32'h138);
    check_out(1'b1);
    wait_rst(1'b0);
    check_out(1'b0);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped error", err, 1'b1);
    check("unmapped read", rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, srw_pkg::CTRL_OFS, ctrl(1'b0, 1'b0, 1'b0, 2'(i), 4'h9));
      trip(4'h8, hdl[i]);
    end
    // Disabled sources must never start a reset.
    apb(1'b1, srw_pkg::CTRL_OFS, ctrl(1'b0, 1'b0, 1'b0, 2'h0, 4'h9));
    flags <= 3'h6;
    repeat (10) @(posedge pclk);
    check("masked sources", reset_out, 1'b0);
    flags <= 3'h0;
    // Only the low byte lane is written, so the manual enable in bit 8 survives.
    pstrb <= 4'h1;
    apb(1'b1, srw_pkg::CTRL_OFS, ctrl(1'b0, 1'b0, 1'b0, 2'h0, 4'h6));
    pstrb <= 4'hf;
    apb(1'b0, srw_pkg::CTRL_OFS, 32'h0);
    check("byte lane mask", rd, 32'h1c0);
    apb(1'b1, srw_pkg::CTRL_OFS, ctrl(1'b0, 1'b0, 1'b0, 2'h0, 4'hf));
    for (int j = 0; j < 3; j++)
      trip(4'(1 << j), hdl[0]);
    // Each watchdog mode: kicks keep it quiet, silence trips it after its own span.
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, srw_pkg::CTRL_OFS, ctrl(1'b1, m[1], m[0], 2'h0, 4'h9));
      kick_en <= 1'b1;
      repeat (3 * wdl[m]) @(posedge pclk);
      check("kicked watchdog", reset_out, 1'b0);
      kick_en <= 1'b0;
      wait_rst(1'b1);
      check("expiry distance", 32'(since >= wdl[m] - 2 && since <= wdl[m] + 4), 32'h1);
      kick_en <= 1'b1;
      wait_rst(1'b0);
      apb(1'b0, srw_pkg::STATUS_OFS, 32'h0);
      check("expiry flag", rd[srw_pkg::STAT_WD_SEEN], 1'b1);
      apb(1'b1, srw_pkg::STATUS_OFS, 32'h20);
      apb(1'b0, srw_pkg::STATUS_OFS, 32'h0);
      check("expiry flag cleared", rd[srw_pkg::STAT_WD_SEEN], 1'b0);
    end
    apb(1'b1, srw_pkg::CTRL_OFS, ctrl(1'b0, 1'b0, 1'b0, 2'h0, 4'h9));
    kick_en <= 1'b0;
    repeat (150) @(posedge pclk);
    check("disabled watchdog", reset_out, 1'b0);
    // A low clock enable freezes the sequencer even with the manual reset held low.
    ce <= 1'b0;
    manual_reset_n <= 1'b0;
    repeat (10) @(posedge pclk);
    check("frozen sequencer", reset_out, 1'b0);
    ce <= 1'b1;
    wait_rst(1'b1);
    check("resumed assert delay", n, 32'd1);
    @(posedge pclk);
    manual_reset_n <= 1'b1;
    wait_rst(1'b0);
    check("resumed hold span", n, hdl[0] + 32'd1);
    end_of_test();
  end
endmodule
